// >>> verilog/udb_defines.svh
// Constants of the Ultra DMA burst engine: pin positions, seed, timing.
`ifndef UDB_DEFINES_SVH
`define UDB_DEFINES_SVH

// Positions inside the synchroniser vector
`define UDB_SY_DMACK 0
`define UDB_SY_STOP 1
`define UDB_SY_HRS 2
`define UDB_SY_DD_LO 3
`define UDB_SY_DD_HI 18
`define UDB_SY_W 19

// Burst CRC
`define UDB_CRC_SEED 16'h4aba

// Timing: clock period and strobe spacing in ns, counts derived (least times round up)
`define UDB_CLK_NS 20
`define UDB_STB_MIN_NS 60
`define UDB_STB_MIN_CYC ((`UDB_STB_MIN_NS + `UDB_CLK_NS - 1) / `UDB_CLK_NS)
`define UDB_TERM_WAIT_NS 200
`define UDB_TERM_WAIT_CYC ((`UDB_TERM_WAIT_NS + `UDB_CLK_NS - 1) / `UDB_CLK_NS)

// Words per sector; a burst ends on every sector boundary
`define UDB_SECTOR_WORDS 9'h100

`endif

// >>> verilog/udb_pkg.sv
// Types shared by the Ultra DMA burst engine.
package udb_pkg;

	typedef enum logic [2:0]
	{
		UDB_IDLE,
		UDB_REQ,
		UDB_INIT,
		UDB_XFER,
		UDB_PAUSE_WAIT,
		UDB_DEV_TERM,
		UDB_STB_RET,
		UDB_CRC
	} udb_state_t;

endpackage

// >>> verilog/udb_crc.sv
// Burst CRC register with its 16-bit parallel next-value logic.
`timescale 1ns/10ps
`include "udb_defines.svh"

module udb_crc
(
	input wire logic sys_clk_i,            // System clock
	input wire logic rst_n_i,              // Synchronous reset, active low
	input wire logic seed_i,               // Reload the seed
	input wire logic upd_i,                // Fold in one data word
	input wire logic [15:0] data_i,        // Word on the bus
	output logic [15:0] current_crc_value_o // Registered CRC
);

	logic [16:1] f;
	logic [15:0] next_crc_value;
	logic [15:0] c;

	always_comb
	begin
		c = current_crc_value_o;
		f[1] = data_i[0] ^ c[15];
		f[2] = data_i[1] ^ c[14];
		f[3] = data_i[2] ^ c[13];
		f[4] = data_i[3] ^ c[12];
		f[5] = data_i[4] ^ c[11] ^ f[1];
		f[6] = data_i[5] ^ c[10] ^ f[2];
		f[7] = data_i[6] ^ c[9] ^ f[3];
		f[8] = data_i[7] ^ c[8] ^ f[4];
		f[9] = data_i[8] ^ c[7] ^ f[5];
		f[10] = data_i[9] ^ c[6] ^ f[6];
		f[11] = data_i[10] ^ c[5] ^ f[7];
		f[12] = data_i[11] ^ c[4] ^ f[1] ^ f[8];
		f[13] = data_i[12] ^ c[3] ^ f[2] ^ f[9];
		f[14] = data_i[13] ^ c[2] ^ f[3] ^ f[10];
		f[15] = data_i[14] ^ c[1] ^ f[4] ^ f[11];
		f[16] = data_i[15] ^ c[0] ^ f[5] ^ f[12];
		next_crc_value[0] = f[16];
		next_crc_value[1] = f[15];
		next_crc_value[2] = f[14];
		next_crc_value[3] = f[13];
		next_crc_value[4] = f[12];
		next_crc_value[5] = f[11] ^ f[16];
		next_crc_value[6] = f[10] ^ f[15];
		next_crc_value[7] = f[9] ^ f[14];
		next_crc_value[8] = f[8] ^ f[13];
		next_crc_value[9] = f[7] ^ f[12];
		next_crc_value[10] = f[6] ^ f[11];
		next_crc_value[11] = f[5] ^ f[10];
		next_crc_value[12] = f[4] ^ f[9] ^ f[16];
		next_crc_value[13] = f[3] ^ f[8] ^ f[15];
		next_crc_value[14] = f[2] ^ f[7] ^ f[14];
		next_crc_value[15] = f[1] ^ f[6] ^ f[13];
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i || seed_i)
			current_crc_value_o <= `UDB_CRC_SEED;
		else if (upd_i)
			current_crc_value_o <= next_crc_value;
	end

endmodule

// >>> verilog/udb_engine.sv
// Ultra DMA burst engine of the drive: initiation, pause, termination and CRC check.
`timescale 1ns/10ps
`include "udb_defines.svh"

module udb_engine
	import udb_pkg::*;
(
	input wire logic sys_clk_i,          // 50 MHz system clock
	input wire logic rst_n_i,            // Synchronous reset, active low
	// Command side
	input wire logic udma_en_i,          // Ultra DMA mode enabled
	input wire logic burst_req_i,        // Start a burst when idle
	input wire logic dir_in_i,           // 1: data in (drive sends), 0: data out
	input wire logic cmd_start_i,        // New command, clears the CRC error
	input wire logic cmd_abort_i,        // Host hard or soft reset seen
	input wire logic dev_pause_i,        // Drive wants to pause (data-out bursts only; ignored while the drive sends)
	input wire logic dev_stop_i,         // Drive wants to end the burst
	input wire logic [15:0] tx_data_i,   // Word to send
	input wire logic tx_valid_i,         // Word to send is valid
	output logic tx_ack_o,               // Pulse: word taken
	output logic [15:0] rx_data_o,       // Received word
	output logic rx_valid_o,             // Pulse: received word valid
	output logic burst_done_o,           // Pulse: burst ended, CRC checked
	output logic crc_err_o,              // Sticky CRC mismatch
	output logic busy_o,                 // Burst in progress
	// Host pins
	output logic dmarq_o,                // DMA request, active high
	input wire logic dmack_n_i,          // DMA acknowledge, active low
	input wire logic stop_i,             // Host stop, active high
	input wire logic hrdy_hstb_i,        // Host ready (low) or host strobe
	output logic drdy_dstb_o,            // Drive ready (low) or drive strobe
	input wire logic [15:0] dd_i,        // Data bus in
	output logic [15:0] dd_o,            // Data bus out
	output logic dd_oe_n_o               // Data bus enable, low while driving
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; data shares the stages so it stays aligned to strobe

	logic [`UDB_SY_W-1:0] meta_q;
	logic [`UDB_SY_W-1:0] sync_q;
	logic [`UDB_SY_W-1:0] prev_q;
	logic [`UDB_SY_W-1:0] pins;

	assign pins = {dd_i, hrdy_hstb_i, stop_i, dmack_n_i};

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end
		else
		begin
			meta_q <= pins;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	logic ack_s;
	logic stop_s;
	logic hrs_s;
	logic hstb_edge;
	logic ack_end;
	logic [15:0] dd_s;

	assign ack_s = !sync_q[`UDB_SY_DMACK];
	assign stop_s = sync_q[`UDB_SY_STOP];
	assign hrs_s = sync_q[`UDB_SY_HRS];
	assign hstb_edge = sync_q[`UDB_SY_HRS] ^ prev_q[`UDB_SY_HRS];
	assign ack_end = sync_q[`UDB_SY_DMACK] && !prev_q[`UDB_SY_DMACK];
	assign dd_s = sync_q[`UDB_SY_DD_HI:`UDB_SY_DD_LO];

	////////////////////////////////////////////////////////////////////////
	// Burst state

	udb_state_t state_q;
	logic dir_q;
	logic first_q;
	logic pend_q;
	logic dmarq_q;
	logic rs_q;
	logic oe_n_q;
	logic [15:0] dd_q;
	logic [3:0] gap_q;
	logic [3:0] wait_q;
	logic [8:0] words_q;
	logic crc_seed;
	logic crc_upd;
	logic [15:0] crc_data;
	logic [15:0] crc_val;
	logic sector_end;
	logic rx_take;
	logic can_send;
	logic sector_last;

	assign sector_end = (words_q == `UDB_SECTOR_WORDS);
	// Ready drops on the last word of a sector, so a host that samples it at its next strobe stops there
	assign sector_last = rx_take && (words_q == `UDB_SECTOR_WORDS - 9'h001);
	assign rx_take = (state_q == UDB_XFER || state_q == UDB_PAUSE_WAIT) && !dir_q && hstb_edge
		&& dmarq_q && !stop_s;
	assign can_send = state_q == UDB_XFER && dir_q && !stop_s && !hrs_s;
	assign crc_seed = state_q == UDB_IDLE;
	assign crc_upd = (pend_q && can_send) || rx_take;
	assign crc_data = dir_q ? dd_q : dd_s;

	udb_crc u_crc
	(
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.seed_i(crc_seed),
		.upd_i(crc_upd),
		.data_i(crc_data),
		.current_crc_value_o(crc_val)
	);

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i || cmd_abort_i)
		begin
			state_q <= UDB_IDLE;
			dmarq_q <= 1'b0;
			dir_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				UDB_IDLE:
					if (udma_en_i && burst_req_i)
					begin
						dmarq_q <= 1'b1;
						dir_q <= dir_in_i;
						state_q <= UDB_REQ;
					end
				UDB_REQ:
					if (ack_s)
						state_q <= dir_q ? UDB_INIT : UDB_XFER;
				UDB_INIT:
					if (!stop_s && !hrs_s)
						state_q <= UDB_XFER;
				UDB_XFER:
					if (stop_s)
					begin
						dmarq_q <= 1'b0;
						state_q <= dir_q ? UDB_STB_RET : UDB_CRC;
					end
					else if (dir_q && !pend_q && (dev_stop_i || sector_end))
					begin
						dmarq_q <= 1'b0;
						state_q <= UDB_DEV_TERM;
					end
					else if (!dir_q && first_q && (dev_stop_i || sector_end))
						state_q <= UDB_PAUSE_WAIT;
				UDB_PAUSE_WAIT:
					if (stop_s)
					begin
						dmarq_q <= 1'b0;
						state_q <= UDB_CRC;
					end
					else if (wait_q == 4'h0)
					begin
						dmarq_q <= 1'b0;
						state_q <= UDB_DEV_TERM;
					end
				UDB_DEV_TERM:
					if (stop_s)
						state_q <= dir_q ? UDB_STB_RET : UDB_CRC;
				UDB_STB_RET:
					state_q <= UDB_CRC;
				UDB_CRC:
					if (ack_end)
						state_q <= UDB_IDLE;
			endcase
		end
	end

	// Pause interval counter before a receiver termination
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i || state_q != UDB_PAUSE_WAIT)
			wait_q <= 4'(`UDB_TERM_WAIT_CYC - 1);
		else if (wait_q != 4'h0)
			wait_q <= wait_q - 4'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// Strobe or ready line and data bus

	// Data-in: a word is loaded one cycle before its strobe edge for setup
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i || state_q == UDB_IDLE)
		begin
			rs_q <= 1'b1;
			pend_q <= 1'b0;
			gap_q <= 4'h0;
			first_q <= 1'b0;
			dd_q <= 16'h0000;
			tx_ack_o <= 1'b0;
		end
		else
		begin
			tx_ack_o <= 1'b0;
			if (gap_q != 4'h0)
				gap_q <= gap_q - 4'h1;
			if (dir_q)
			begin
				if (state_q == UDB_STB_RET)
				begin
					rs_q <= 1'b1;
					pend_q <= 1'b0;
				end
				else if (pend_q && can_send)
				begin
					rs_q <= !rs_q;
					pend_q <= 1'b0;
					first_q <= 1'b1;
					gap_q <= 4'(`UDB_STB_MIN_CYC - 1);
				end
				else if (can_send && !pend_q && gap_q == 4'h0 && tx_valid_i && !dev_stop_i
					&& !sector_end)
				begin
					dd_q <= tx_data_i;
					pend_q <= 1'b1;
					tx_ack_o <= 1'b1;
				end
			end
			else
			begin
				if (rx_take)
					first_q <= 1'b1;
				if (state_q == UDB_PAUSE_WAIT || state_q == UDB_DEV_TERM || state_q == UDB_CRC)
					rs_q <= 1'b1;
				else if (state_q == UDB_XFER && (sector_last || sector_end))
					rs_q <= 1'b1;
				else if (state_q == UDB_XFER && first_q && dev_pause_i)
					rs_q <= 1'b1;
				else if (state_q == UDB_XFER)
					rs_q <= 1'b0;
			end
		end
	end

	// Bus released before the host returns its CRC
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			oe_n_q <= 1'b1;
		else if (state_q == UDB_INIT && !stop_s && !hrs_s && ack_s)
			oe_n_q <= 1'b0;
		else if (state_q == UDB_STB_RET || state_q == UDB_IDLE || state_q == UDB_CRC)
			oe_n_q <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Receive path, sector count and CRC check

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			rx_data_o <= 16'h0000;
			rx_valid_o <= 1'b0;
		end
		else
		begin
			rx_valid_o <= rx_take;
			if (rx_take)
				rx_data_o <= dd_s;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i || state_q == UDB_IDLE)
			words_q <= 9'h000;
		else if (crc_upd && !sector_end)
			words_q <= words_q + 9'h001;
	end

	// A mismatch seen in the clearing cycle still sets the flag
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			crc_err_o <= 1'b0;
		else if (state_q == UDB_CRC && ack_end && dd_s != crc_val)
			crc_err_o <= 1'b1;
		else if (cmd_start_i || cmd_abort_i)
			crc_err_o <= 1'b0;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			burst_done_o <= 1'b0;
			busy_o <= 1'b0;
		end
		else
		begin
			burst_done_o <= state_q == UDB_CRC && ack_end && !cmd_abort_i;
			busy_o <= !(state_q == UDB_IDLE) && !cmd_abort_i;
		end
	end

	assign dmarq_o = dmarq_q;
	assign drdy_dstb_o = rs_q;
	assign dd_o = dd_q;
	assign dd_oe_n_o = oe_n_q;

endmodule

// >>> tb/udb_engine_monitor.sv
// Checker of the burst engine pin and command behaviour.
`timescale 1ns/10ps

module udb_engine_monitor
(
	input wire logic sys_clk_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic udma_en_i, // Mode on
	input wire logic burst_req_i, // Start
	input wire logic dir_in_i, // Direction
	input wire logic cmd_start_i, // Error clear
	input wire logic cmd_abort_i, // Abort
	input wire logic tx_ack_o, // Word taken
	input wire logic rx_valid_o, // Word received
	input wire logic burst_done_o, // Burst ended
	input wire logic crc_err_o, // CRC error
	input wire logic busy_o, // Busy
	input wire logic dmarq_o, // Request
	input wire logic dmack_n_i, // Acknowledge
	input wire logic stop_i, // Stop
	input wire logic hrdy_hstb_i, // Host ready or strobe
	input wire logic drdy_dstb_o, // Drive ready or strobe
	input wire logic dd_oe_n_o // Bus enable
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_req_start: assert property (udma_en_i && burst_req_i && !busy_o && !dmarq_o && !cmd_abort_i |=> dmarq_o)
		else $error("request not raised");
	chk_mode_gate: assert property ($rose(dmarq_o) |-> $past(udma_en_i))
		else $error("request while mode off");
	chk_bus_grant: assert property ($fell(dd_oe_n_o) |-> dmarq_o && !dmack_n_i && !stop_i && !hrdy_hstb_i)
		else $error("bus driven too early");
	chk_out_hold: assert property (!dir_in_i && dmarq_o && $fell(drdy_dstb_o) |-> (dmarq_o && !drdy_dstb_o) [*3])
		else $error("ready dropped before strobe");
	chk_host_stop: assert property (dmarq_o && $rose(stop_i) |-> ##[1:5] !dmarq_o)
		else $error("stop not acknowledged");
	chk_rx_ignore: assert property (stop_i [*8] |-> !rx_valid_o)
		else $error("word taken under stop");
	chk_ack_space: assert property (tx_ack_o |=> !tx_ack_o [*2])
		else $error("strobes too close");
	chk_ret_strobe: assert property ($rose(dd_oe_n_o) |-> drdy_dstb_o)
		else $error("strobe not returned");
	chk_err_cause: assert property ($rose(crc_err_o) |-> burst_done_o)
		else $error("error outside burst end");
	chk_err_sticky: assert property (crc_err_o && !cmd_start_i && !cmd_abort_i |=> crc_err_o)
		else $error("error flag lost");
	chk_done_busy: assert property (burst_done_o |-> busy_o ##1 !busy_o)
		else $error("busy after burst end");
endmodule

bind udb_engine udb_engine_monitor mon (.*);

// >>> tb/udb_host_model.sv
// Behavioural host controller that runs Ultra DMA bursts.
`timescale 1ns/10ps
`include "udb_defines.svh"

module udb_host_model
(
	input wire logic sys_clk_i, // Clock
	input wire logic dir_in_i, // 1: drive sends
	input wire logic end_i, // Host ends the burst
	input wire logic bad_crc_i, // Corrupt the returned CRC
	input wire logic [15:0] seed_word_i, // Base of sent words
	input wire logic dmarq_i, // Drive request
	input wire logic drdy_dstb_i, // Drive ready or strobe
	input wire logic [15:0] dd_i, // Bus level
	input wire logic dd_oe_n_i, // Drive bus enable
	output logic dmack_n_o, // Acknowledge
	output logic stop_o, // Stop
	output logic hrdy_hstb_o, // Host ready or strobe
	output logic [15:0] dd_o, // Host data
	output logic evt_o, // Word moved
	output logic [15:0] word_o // That word
);
	logic [15:0] crc_q;
	logic prev_q;
	int ph_q;
	int cnt_q;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
		for (int i = 0; i < 16; i++)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction

	initial
	begin
		dmack_n_o = 1'b1;
		stop_o = 1'b1;
		hrdy_hstb_o = 1'b1;
		dd_o = 16'h0000;
		evt_o = 1'b0;
		ph_q = 0;
		cnt_q = 0;
	end

	always @(posedge sys_clk_i)
	begin
		prev_q <= drdy_dstb_i;
		evt_o <= 1'b0;
		cnt_q <= cnt_q + 1;
		if (ph_q < 3 && (dir_in_i || ph_q == 0))
			dd_o <= ~dd_o; // Released bus must not keep the last word
		// Words still in flight while pausing must be taken as well
		if ((ph_q == 1 || ph_q == 2) && dir_in_i && dmarq_i && drdy_dstb_i != prev_q && !stop_o && !dd_oe_n_i)
		begin
			crc_q <= crc_step(crc_q, dd_i);
			word_o <= dd_i;
			evt_o <= 1'b1;
		end
		if (ph_q == 0 && dmarq_i && cnt_q > 3)
		begin
			dmack_n_o <= 1'b0;
			stop_o <= 1'b0;
			hrdy_hstb_o <= !dir_in_i;
			crc_q <= `UDB_CRC_SEED;
			cnt_q <= 0;
			ph_q <= 1;
		end
		else if (ph_q == 1 && !dmarq_i)
		begin
			stop_o <= 1'b1;
			hrdy_hstb_o <= 1'b1;
			ph_q <= 3;
			cnt_q <= 0;
		end
		else if (ph_q == 1 && end_i)
		begin
			if (dir_in_i)
				hrdy_hstb_o <= 1'b1;
			ph_q <= 2;
			cnt_q <= 0;
		end
		else if (ph_q == 1 && !dir_in_i && !drdy_dstb_i && cnt_q > 2)
		begin
			hrdy_hstb_o <= ~hrdy_hstb_o;
			dd_o <= seed_word_i ^ crc_q;
			crc_q <= crc_step(crc_q, seed_word_i ^ crc_q);
			word_o <= seed_word_i ^ crc_q;
			evt_o <= 1'b1;
			cnt_q <= 0;
		end
		else if (ph_q == 2)
		begin
			if (cnt_q == 6)
				stop_o <= 1'b1;
			if (stop_o && !dmarq_i)
			begin
				hrdy_hstb_o <= 1'b1;
				ph_q <= 3;
				cnt_q <= 0;
			end
		end
		else if (ph_q == 3)
		begin
			dd_o <= crc_q ^ {15'h0000, bad_crc_i};
			if (cnt_q == 4)
			begin
				dmack_n_o <= 1'b1;
				ph_q <= 4;
			end
		end
		else if (ph_q == 4 && cnt_q == 9)
			ph_q <= 0;
	end
endmodule

// >>> tb/udb_engine_test.sv
// Self-checking bench: burst engine against the host model.
`timescale 1ns/10ps

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end

module udb_engine_test;
	logic sys_clk_i = 1'b0, rst_n_i = 1'b0, udma_en_i = 1'b0, burst_req_i = 1'b0, dir_in_i = 1'b1;
	logic cmd_start_i = 1'b0, cmd_abort_i = 1'b0, dev_pause_i = 1'b0, dev_stop_i = 1'b0, tx_valid_i = 1'b1;
	logic host_end = 1'b0, bad_crc = 1'b0;
	logic [15:0] tx_data_i = 16'h0000, seed_word = 16'h0000;
	logic tx_ack_o, rx_valid_o, burst_done_o, crc_err_o, busy_o, dmarq_o, dmack_n_i, stop_i;
	logic hrdy_hstb_i, drdy_dstb_o, dd_oe_n_o, host_evt;
	logic [15:0] rx_data_o, dd_o, host_dd, host_word, dd_bus;
	logic [15:0] exp_q[$];
	logic [15:0] exp_w;
	int err_count = 0, samples_checked = 0, got = 0;

	always #10 sys_clk_i = ~sys_clk_i;
	assign dd_bus = dd_oe_n_o ? host_dd : dd_o;

	udb_engine dut (.*, .dd_i(dd_bus));
	udb_host_model host (.sys_clk_i(sys_clk_i), .dir_in_i(dir_in_i), .end_i(host_end), .bad_crc_i(bad_crc),
		.seed_word_i(seed_word), .dmarq_i(dmarq_o), .drdy_dstb_i(drdy_dstb_o), .dd_i(dd_bus), .dd_oe_n_i(dd_oe_n_o),
		.dmack_n_o(dmack_n_i), .stop_o(stop_i), .hrdy_hstb_o(hrdy_hstb_i), .dd_o(host_dd), .evt_o(host_evt),
		.word_o(host_word));

	////////////////////////////////////////////////////////////////
	// Sent words are noted, received ones compared in order
	always @(posedge sys_clk_i)
	begin
		if (tx_ack_o)
			tx_data_i <= 16'($urandom);
		if (host_evt)
			got++;
		if (tx_ack_o || (host_evt && !dir_in_i))
			exp_q.push_back(tx_ack_o ? tx_data_i : host_word);
		if (rx_valid_o || (host_evt && dir_in_i))
		begin
			if (exp_q.size() == 0)
				`CHK(1'b1, 1'b0)
			else
			begin
				exp_w = exp_q.pop_front();
				`CHK(rx_valid_o ? rx_data_o : host_word, exp_w)
			end
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	task automatic results();
		$display("comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// nw of 0 lets the sector limit end the burst
	task automatic burst(input logic din, input int nw, input logic hend, input logic bad);
		int k;
		exp_q.delete();
		got = 0;
		dir_in_i <= din;
		bad_crc <= bad;
		seed_word <= 16'($urandom);
		burst_req_i <= 1'b1;
		cyc(1);
		burst_req_i <= 1'b0;
		for (k = 0; k < 3000 && got < nw; k++)
			cyc(1);
		if (got < nw)
		begin
			err_count++;
			results();
		end
		if (!din && nw > 0)
		begin
			dev_pause_i <= 1'b1;
			cyc(10);
			k = got;
			cyc(30);
			`CHK(got, k)
			dev_pause_i <= 1'b0;
			cyc(20);
		end
		host_end <= hend && nw > 0;
		dev_stop_i <= !hend && nw > 0;
		for (k = 0; k < 3000 && !burst_done_o; k++)
			cyc(1);
		host_end <= 1'b0;
		dev_stop_i <= 1'b0;
		if (k == 3000)
		begin
			err_count++;
			results();
		end
		`CHK(crc_err_o, bad)
		if (nw == 0)
			`CHK(got, 256)
		cyc(14);
	endtask

	initial
	begin
		void'($urandom(32'h80217459));
		cyc(5);
		rst_n_i <= 1'b1;
		cyc(3);
		burst_req_i <= 1'b1;
		cyc(10);
		`CHK(dmarq_o, 1'b0)
		burst_req_i <= 1'b0;
		udma_en_i <= 1'b1;
		cyc(2);
		for (int i = 0; i < 6; i++)
			burst(i[0], i < 4 ? 3 + $urandom_range(9) : 0, i[1], 1'b0);
		burst(1'b0, 6, 1'b1, 1'b1);
		cmd_start_i <= 1'b1;
		cyc(1);
		cmd_start_i <= 1'b0;
		cyc(1);
		`CHK(crc_err_o, 1'b0)
		got = 0;
		burst_req_i <= 1'b1;
		dir_in_i <= 1'b1;
		cyc(1);
		burst_req_i <= 1'b0;
		for (int k = 0; k < 500 && got < 3; k++)
			cyc(1);
		if (got < 3)
		begin
			err_count++;
			results();
		end
		cmd_abort_i <= 1'b1;
		cyc(1);
		cmd_abort_i <= 1'b0;
		cyc(2);
		`CHK(dmarq_o, 1'b0)
		`CHK(busy_o, 1'b0)
		cyc(30);
		burst(1'b1, 4, 1'b0, 1'b0);
		results();
	end
endmodule
